// file: core/dsss_params.svh
// Register offsets, field positions, reset values and timing counts of the supply switch sequencer.
`ifndef DSSS_PARAMS_SVH
`define DSSS_PARAMS_SVH
`define DSSS_ADDR_W 16
`define DSSS_OFS_CONTROL 16'h1C00
`define DSSS_OFS_STATUS 16'h1C01
`define DSSS_OFS_FLAGS 16'h1C02
`define DSSS_OFS_MASK 16'h1C03
`define DSSS_OFS_STATE 16'h1C04
`define DSSS_CTL_FORCE_BIT 0
`define DSSS_CTL_ENABLE_N_BIT 1
`define DSSS_CTL_RESET 2'h0
`define DSSS_EVT_BUS_READY 0
`define DSSS_EVT_BUS_LOST 1
`define DSSS_EVT_MAIN_READY 2
`define DSSS_EVT_MAIN_LOST 3
`define DSSS_EVT_BUS_TO_MAIN 4
`define DSSS_EVT_MAIN_TO_BUS 5
`define DSSS_EVT_RESET 6'h00
`define DSSS_CLK_MHZ 100
`define DSSS_STEP_US 50
`define DSSS_STEP_CYCLES (`DSSS_STEP_US * `DSSS_CLK_MHZ)
`define DSSS_CNT_W 13
`endif

// file: core/dsss_pkg.sv
// Types shared by the supply switch sequencer.
package dsss_pkg;
  typedef enum logic [3:0] {
    DSSS_ST_INIT,
    DSSS_ST_MAIN_D_OPEN,
    DSSS_ST_MAIN,
    DSSS_ST_BUS,
    DSSS_ST_UP_C_OPEN,
    DSSS_ST_UP_B_SHORT,
    DSSS_ST_UP_D_OPEN,
    DSSS_ST_DN_A_OPEN,
    DSSS_ST_DN_D_CLOSE,
    DSSS_ST_DN_B_OPEN
  } dsss_state_type;

  typedef struct packed {
    logic fet_a;
    logic fet_b;
    logic fet_c;
    logic fet_d;
  } dsss_fets_type;

  typedef struct packed {
    logic [2:0] bus_sync;
    logic [2:0] main_sync;
    logic [2:0] core_sync;
    logic bus_good;
    logic main_good;
    logic core_good;
    dsss_state_type state;
    logic [12:0] count;
    dsss_fets_type fets;
    logic force_bus_rail;
    logic switch_enable_n;
    logic [5:0] flags;
    logic [5:0] mask;
    logic [7:0] rdata;
  } dsss_regs_type;
endpackage : dsss_pkg

// file: core/dsss_sequencer.sv
// Supply switch sequencer: rail selection, FET stepping, reset hold and event registers.
`timescale 1ns/10ps
`include "dsss_params.svh"
// What this block does
// - Core reset is held while the core voltage good input is low.
// - Reset is also held while neither rail good input is high.
// - With no rail good, FETs A and C are open, B and D closed.
// - Main rail alone: open D, then short A after 50us.
// - Bus rail alone: enable the regulator and run, never back-driving the main rail.
// - Running on bus rail, main rail good starts handover by opening C.
// - Handover shorts B 50us after C opens.
// - Handover opens D 50us after B shorts.
// - Handover shorts A 50us after D opens, main rail feeds core.
// - On main rail, bus rail arriving changes no FET unless force bus rail is set.
// - Both present, bus rail lost: supply unchanged, lost event raised.
// - Both present, main rail lost: first open A.
// - Main loss: close D 50us after A opens.
// - Main loss: open B 50us after the previous step.
// - Main loss: short C 50us after B opens, bus rail feeds core.
// - Main rail is chosen automatically unless force bus rail is set.
// - Force bus rail, control bit 0 reset 0, acts only on main with bus present.
// - Switch enable, control bit 1, is active low and resets to 0.
// - Interrupt stays high until every asserted flag with its mask bit set is cleared or has its mask bit cleared.
// - Each event is maskable by its own mask bit.
// - Stored flags gated by their mask bits drive a wake output equal to the interrupt.
// - Five registers decode at consecutive byte addresses from 1C00h; above is reserved.
// - Ready flags set on rising rail status, lost flags on falling.
// - Writing 1 clears a flag, writing 0 leaves it.
// - Setting force bus rail raises the main-to-bus switchover flag.
// - A masked event produces no interrupt.
module dsss_sequencer
  import dsss_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic BUS_RAIL_GOOD,
  input wire logic MAIN_RAIL_GOOD,
  input wire logic CORE_VOLTAGE_GOOD,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic FET_A_SHORT,
  output logic FET_B_SHORT,
  output logic FET_C_SHORT,
  output logic FET_D_SHORT,
  output logic REGULATOR_ON,
  output logic SWITCH_ENABLE_N,
  output logic CORE_RESET_N,
  output logic IRQ,
  output logic WAKE
);

  // ==========================================================
  // FET patterns
  // ==========================================================
  // Returns a FET set; a one means the switch is shorted.
  function automatic dsss_fets_type fets(input logic a, input logic b,
                                         input logic c, input logic d);
    fets = '{fet_a: a, fet_b: b, fet_c: c, fet_d: d};
  endfunction : fets

  localparam logic [12:0] STEP_LAST = 13'(`DSSS_STEP_CYCLES - 1);

  // Switch set of the power-up state: A and C open, B and D closed.
  localparam dsss_fets_type FETS_POWER_UP =
    '{fet_a: 1'b0, fet_b: 1'b1, fet_c: 1'b0, fet_d: 1'b1};
  // Switch set of the bus-only state: C feeds the core straight from the bus rail.
  localparam dsss_fets_type FETS_BUS =
    '{fet_a: 1'b0, fet_b: 1'b0, fet_c: 1'b1, fet_d: 1'b1};

  // ==========================================================
  // Helpers
  // ==========================================================
  // True when the bus address selects the given register.
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
    hit = addr == ofs;
  endfunction : hit

  // Takes a new level only once the last two synchroniser stages agree.
  function automatic logic settle(input logic [2:0] sync, input logic held);
    if (sync[2] == sync[1]) begin
      settle = sync[2];
    end else begin
      settle = held;
    end
  endfunction : settle

  // True on a low-to-high change between two settled levels.
  function automatic logic went_high(input logic now_lvl, input logic was_lvl);
    went_high = now_lvl & ~was_lvl;
  endfunction : went_high

  // True on a high-to-low change between two settled levels.
  function automatic logic went_low(input logic now_lvl, input logic was_lvl);
    went_low = ~now_lvl & was_lvl;
  endfunction : went_low

  // Automatic choice: main rail, unless software forces the bus rail while it is good.
  function automatic logic want_main(input logic main_lvl, input logic bus_lvl,
                                     input logic force_bus);
    want_main = main_lvl & ~(force_bus & bus_lvl);
  endfunction : want_main

  // Step counter: counts up and rests at the last count of a step.
  function automatic logic [12:0] next_count(input logic [12:0] count, input logic done);
    if (done) begin
      next_count = count;
    end else begin
      next_count = count + 13'h0001;
    end
  endfunction : next_count

  // Clears the flags written with ones, then lets new events set theirs.
  function automatic logic [5:0] flag_update(input logic [5:0] held, input logic clear_en,
                                             input logic [5:0] clear_bits,
                                             input logic [5:0] events);
    logic [5:0] kept;
    kept = held;
    if (clear_en) begin
      kept = held & ~clear_bits;
    end
    flag_update = kept | events;
  endfunction : flag_update

  // Core runs only with the core voltage good and at least one rail good.
  function automatic logic core_release(input logic core_lvl, input logic bus_lvl,
                                        input logic main_lvl);
    core_release = core_lvl & (bus_lvl | main_lvl);
  endfunction : core_release

  // Interrupt level: any stored flag whose mask bit is set.
  function automatic logic pending(input logic [5:0] flags, input logic [5:0] mask);
    pending = |(flags & mask);
  endfunction : pending

  // Control image: bit 1 switch enable, active low, bit 0 force bus rail.
  function automatic logic [7:0] control_byte(input logic enable_n, input logic force_bus);
    control_byte = {6'h00, enable_n, force_bus};
  endfunction : control_byte

  // Status image: settled rail levels, core release and the two rail switches.
  function automatic logic [7:0] status_byte(input logic main_lvl, input logic bus_lvl,
                                             input logic core_ok, input dsss_fets_type f);
    status_byte = {2'h0, main_lvl, bus_lvl, 1'b0, core_ok, f.fet_a, f.fet_c};
  endfunction : status_byte

  // Switch state image: bit 1 bus rail switch, bit 0 main rail switch.
  function automatic logic [7:0] state_byte(input dsss_fets_type f);
    state_byte = {6'h00, f.fet_c, f.fet_a};
  endfunction : state_byte

  // Widens a six-bit register to the byte read back; the top bits read zero.
  function automatic logic [7:0] pad6(input logic [5:0] v);
    pad6 = {2'h0, v};
  endfunction : pad6

  // Read data of one register; unmapped and reserved addresses read zero.
  function automatic logic [7:0] read_mux(input logic [15:0] addr, input dsss_regs_type s);
    unique case (addr)
      `DSSS_OFS_CONTROL: read_mux = control_byte(s.switch_enable_n, s.force_bus_rail);
      `DSSS_OFS_STATUS: read_mux = status_byte(s.main_good, s.bus_good,
                                               core_release(s.core_good, s.bus_good, s.main_good),
                                               s.fets);
      `DSSS_OFS_FLAGS: read_mux = pad6(s.flags);
      `DSSS_OFS_MASK: read_mux = pad6(s.mask);
      `DSSS_OFS_STATE: read_mux = state_byte(s.fets);
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  dsss_regs_type r_reg;
  dsss_regs_type r_next;

  logic bus_rise;
  logic bus_fall;
  logic main_rise;
  logic main_fall;
  logic step_done;
  logic wr_ctl;
  logic wr_flags;
  logic wr_mask;
  logic [5:0] set_ev;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    r_next = r_reg;
    // Third and second stages must agree before a level is taken.
    r_next.bus_sync = {r_reg.bus_sync[1:0], BUS_RAIL_GOOD};
    r_next.main_sync = {r_reg.main_sync[1:0], MAIN_RAIL_GOOD};
    r_next.core_sync = {r_reg.core_sync[1:0], CORE_VOLTAGE_GOOD};
    r_next.bus_good = settle(r_reg.bus_sync, r_reg.bus_good);
    r_next.main_good = settle(r_reg.main_sync, r_reg.main_good);
    r_next.core_good = settle(r_reg.core_sync, r_reg.core_good);

    bus_rise = went_high(r_next.bus_good, r_reg.bus_good);
    bus_fall = went_low(r_next.bus_good, r_reg.bus_good);
    main_rise = went_high(r_next.main_good, r_reg.main_good);
    main_fall = went_low(r_next.main_good, r_reg.main_good);

    // Register writes.
    wr_ctl = WR && hit(ADDR, `DSSS_OFS_CONTROL);
    wr_flags = WR && hit(ADDR, `DSSS_OFS_FLAGS);
    wr_mask = WR && hit(ADDR, `DSSS_OFS_MASK);
    set_ev = '0;

    if (wr_ctl) begin
      r_next.force_bus_rail = WDATA[`DSSS_CTL_FORCE_BIT];
      r_next.switch_enable_n = WDATA[`DSSS_CTL_ENABLE_N_BIT];
      if (WDATA[`DSSS_CTL_FORCE_BIT] && !r_reg.force_bus_rail) begin
        set_ev[`DSSS_EVT_MAIN_TO_BUS] = 1'b1;
      end
    end
    if (wr_mask) begin
      r_next.mask = WDATA[5:0];
    end

    // Step counter restarts on every state change.
    step_done = r_reg.count == STEP_LAST;
    r_next.count = next_count(r_reg.count, step_done);

    // Switch sequencing: every step is a FET change made as a state is entered.
    unique case (r_reg.state)
      DSSS_ST_INIT: begin
        // The diodes on A and C keep either rail from driving the other.
        r_next.fets = FETS_POWER_UP;
        if (want_main(r_reg.main_good, r_reg.bus_good, r_reg.force_bus_rail)) begin
          // D opens with the state entry, so the 50us to the A short starts here.
          r_next.fets.fet_d = 1'b0;
          r_next.state = DSSS_ST_MAIN_D_OPEN;
        end else if (r_reg.bus_good) begin
          r_next.fets = FETS_BUS;
          r_next.state = DSSS_ST_BUS;
        end
      end
      DSSS_ST_MAIN_D_OPEN: begin
        r_next.fets.fet_d = 1'b0;
        if (!r_reg.main_good) begin
          // Main rail gone before A shorted: start over from power-up.
          r_next.state = DSSS_ST_INIT;
        end else if (step_done) begin
          r_next.fets.fet_a = 1'b1;
          r_next.state = DSSS_ST_MAIN;
          set_ev[`DSSS_EVT_BUS_TO_MAIN] = r_reg.fets.fet_c | r_reg.bus_good;
        end
      end
      DSSS_ST_MAIN: begin
        // Bus rail going leaves the FETs alone; bus rail coming moves them only with force bus rail set.
        if (!r_reg.main_good) begin
          r_next.fets.fet_a = 1'b0;
          r_next.state = DSSS_ST_DN_A_OPEN;
        end else if (!want_main(r_reg.main_good, r_reg.bus_good, r_reg.force_bus_rail)) begin
          // Forced move to the bus rail walks the same steps as a main rail loss.
          r_next.fets.fet_a = 1'b0;
          r_next.state = DSSS_ST_DN_A_OPEN;
        end
      end
      DSSS_ST_BUS: begin
        if (!r_reg.bus_good) begin
          r_next.state = DSSS_ST_INIT;
        end else if (want_main(r_reg.main_good, r_reg.bus_good, r_reg.force_bus_rail)) begin
          // C opens first, so the bus rail reaches the core only through its diode.
          r_next.fets.fet_c = 1'b0;
          r_next.state = DSSS_ST_UP_C_OPEN;
        end
      end
      DSSS_ST_UP_C_OPEN: begin
        if (step_done) begin
          // Both diodes now conduct; the higher rail feeds the core.
          r_next.fets.fet_b = 1'b1;
          r_next.state = DSSS_ST_UP_B_SHORT;
        end
      end
      DSSS_ST_UP_B_SHORT: begin
        if (step_done) begin
          // The bus rail path is cut before the main diode is bypassed.
          r_next.fets.fet_d = 1'b0;
          r_next.state = DSSS_ST_UP_D_OPEN;
        end
      end
      DSSS_ST_UP_D_OPEN: begin
        if (step_done) begin
          // Bypassing the diode last removes its drop without back-drive.
          r_next.fets.fet_a = 1'b1;
          r_next.state = DSSS_ST_MAIN;
          set_ev[`DSSS_EVT_BUS_TO_MAIN] = 1'b1;
        end
      end
      DSSS_ST_DN_A_OPEN: begin
        if (step_done) begin
          // Back to the power-up set; the core may drop out of regulation here.
          r_next.fets.fet_d = 1'b1;
          r_next.state = DSSS_ST_DN_D_CLOSE;
        end
      end
      DSSS_ST_DN_D_CLOSE: begin
        if (step_done) begin
          // Main rail path cut; the bus rail feeds the core through its diode.
          r_next.fets.fet_b = 1'b0;
          r_next.state = DSSS_ST_DN_B_OPEN;
        end
      end
      DSSS_ST_DN_B_OPEN: begin
        if (step_done) begin
          if (r_reg.bus_good) begin
            // Bypassing the bus diode last removes its drop.
            r_next.fets.fet_c = 1'b1;
            r_next.state = DSSS_ST_BUS;
            if (!r_reg.force_bus_rail) begin
              set_ev[`DSSS_EVT_MAIN_TO_BUS] = 1'b1;
            end
          end else begin
            // Bus rail gone as well: nothing is left to hand over to.
            r_next.state = DSSS_ST_INIT;
          end
        end
      end
    endcase
    if (r_next.state != r_reg.state) begin
      r_next.count = '0;
    end

    // Event flags.
    set_ev[`DSSS_EVT_BUS_READY] = bus_rise;
    set_ev[`DSSS_EVT_BUS_LOST] = bus_fall;
    set_ev[`DSSS_EVT_MAIN_READY] = main_rise;
    set_ev[`DSSS_EVT_MAIN_LOST] = main_fall;
    // A new event wins over a clear in the same cycle.
    r_next.flags = flag_update(r_reg.flags, wr_flags, WDATA[5:0], set_ev);

    // Read data stand only in the cycle after the strobe.
    r_next.rdata = 8'h00;
    if (RD) begin
      r_next.rdata = read_mux(ADDR, r_reg);
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Synchronous reset puts the switches in the power-up set.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r_reg <= '{bus_sync: 3'h0, main_sync: 3'h0, core_sync: 3'h0,
                 bus_good: 1'b0, main_good: 1'b0, core_good: 1'b0,
                 state: DSSS_ST_INIT, count: 13'h0000,
                 fets: '{fet_a: 1'b0, fet_b: 1'b1, fet_c: 1'b0, fet_d: 1'b1},
                 force_bus_rail: 1'b0, switch_enable_n: 1'b0,
                 flags: `DSSS_EVT_RESET, mask: 6'h00, rdata: 8'h00};
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign RDATA = r_reg.rdata;
  assign FET_A_SHORT = r_reg.fets.fet_a;
  assign FET_B_SHORT = r_reg.fets.fet_b;
  assign FET_C_SHORT = r_reg.fets.fet_c;
  assign FET_D_SHORT = r_reg.fets.fet_d;
  assign REGULATOR_ON = r_reg.bus_good | r_reg.main_good;
  assign SWITCH_ENABLE_N = r_reg.switch_enable_n;
  assign CORE_RESET_N = core_release(r_reg.core_good, r_reg.bus_good,
                                     r_reg.main_good);
  assign IRQ = pending(r_reg.flags, r_reg.mask);
  // Pure gating of stored flags, so the wake follows IRQ and rises only on a clock edge that stores a flag or sets its mask bit.
  assign WAKE = pending(r_reg.flags, r_reg.mask);

endmodule : dsss_sequencer

// file: tb/dsss_props.sv
// Port assertions of the supply switch sequencer.
`timescale 1ns/10ps
module dsss_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic BUS_RAIL_GOOD,
  input wire logic MAIN_RAIL_GOOD,
  input wire logic CORE_VOLTAGE_GOOD,
  input wire logic [15:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic FET_A_SHORT,
  input wire logic FET_B_SHORT,
  input wire logic FET_C_SHORT,
  input wire logic FET_D_SHORT,
  input wire logic REGULATOR_ON,
  input wire logic CORE_RESET_N,
  input wire logic IRQ,
  input wire logic WAKE
);
  logic [3:0] fets_prev_reg;
  logic [12:0] gap_reg;
  wire [3:0] fets = {FET_A_SHORT, FET_B_SHORT, FET_C_SHORT, FET_D_SHORT};
  wire fets_moved = fets != fets_prev_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Counts the cycles since the switches last changed, saturating.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fets_prev_reg <= 4'h5;
      gap_reg <= 13'h1FFF;
    end else begin
      fets_prev_reg <= fets;
      if (fets_moved) begin
        gap_reg <= 13'h0001;
      end else if (gap_reg != 13'h1FFF) begin
        gap_reg <= gap_reg + 13'h0001;
      end
    end
  end
  a_core_hold: assert property (!CORE_VOLTAGE_GOOD [*8] |-> !CORE_RESET_N)
    else $error("core released while core voltage low");
  a_rail_hold: assert property (
    (!BUS_RAIL_GOOD && !MAIN_RAIL_GOOD) [*8] |-> !CORE_RESET_N)
    else $error("core released with no rail");
  a_bus_only: assert property (
    (BUS_RAIL_GOOD && !MAIN_RAIL_GOOD) [*8] |-> REGULATOR_ON && !FET_A_SHORT)
    else $error("bus rail alone without regulator or with main switch shorted");
  a_step_exact: assert property (
    fets_moved && (fets_prev_reg == 4'h4 || fets_prev_reg == 4'h1) |-> gap_reg == 13'h1388)
    else $error("switch step not 50 us after the previous one");
  a_irq_holds: assert property (
    IRQ && !(WR && (ADDR == 16'h1C02 || ADDR == 16'h1C03)) |=> IRQ)
    else $error("interrupt dropped without a flag or mask write");
  a_wake_same: assert property (WAKE == IRQ)
    else $error("wake differs from interrupt");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside the answer cycle");
  a_reserved_zero: assert property (RD && ADDR >= 16'h1C05 |=> RDATA == 8'h00)
    else $error("reserved address read nonzero");
endmodule : dsss_props
bind dsss_sequencer dsss_props props_u (.CLK(CLK), .RST_N(RST_N), .BUS_RAIL_GOOD(BUS_RAIL_GOOD),
  .MAIN_RAIL_GOOD(MAIN_RAIL_GOOD), .CORE_VOLTAGE_GOOD(CORE_VOLTAGE_GOOD), .ADDR(ADDR), .WR(WR),
  .RD(RD), .RDATA(RDATA), .FET_A_SHORT(FET_A_SHORT), .FET_B_SHORT(FET_B_SHORT),
  .FET_C_SHORT(FET_C_SHORT), .FET_D_SHORT(FET_D_SHORT), .REGULATOR_ON(REGULATOR_ON),
  .CORE_RESET_N(CORE_RESET_N), .IRQ(IRQ), .WAKE(WAKE));

// file: tb/dsss_rails.sv
// Comparator model that turns requested rail levels into good signals.
`timescale 1ns/10ps
module dsss_rails (
  input wire logic clk,
  input wire logic bus_on,
  input wire logic main_on,
  input wire logic core_ok,
  input wire logic reg_on,
  output logic bus_good = 1'b0,
  output logic main_good = 1'b0,
  output logic core_good = 1'b0
);
  // The core voltage only comes good once the regulator runs.
  always @(posedge clk) begin
    bus_good <= bus_on;
    main_good <= main_on;
    core_good <= core_ok && reg_on;
  end
endmodule : dsss_rails

// file: tb/dual_supply_switch_sequencer_tb.sv
// Self-checking bench of the supply switch sequencer.
`timescale 1ns/10ps
module dual_supply_switch_sequencer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_on = 1'b0;
  logic main_on = 1'b0;
  logic core_ok = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic fa, fb, fc, fd, reg_on, sw_en_n, core_rst_n, irq, wake, bg, mg, cg;
  int n_errors = 0;
  int check_count = 0;
  wire [3:0] fets = {fa, fb, fc, fd};
  always #5 clk = ~clk;
  dsss_sequencer dut_u (.CLK(clk), .RST_N(rst_n), .BUS_RAIL_GOOD(bg), .MAIN_RAIL_GOOD(mg),
    .CORE_VOLTAGE_GOOD(cg), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .FET_A_SHORT(fa), .FET_B_SHORT(fb), .FET_C_SHORT(fc), .FET_D_SHORT(fd),
    .REGULATOR_ON(reg_on), .SWITCH_ENABLE_N(sw_en_n), .CORE_RESET_N(core_rst_n),
    .IRQ(irq), .WAKE(wake));
  dsss_rails rails_u (.clk(clk), .bus_on(bus_on), .main_on(main_on), .core_ok(core_ok),
    .reg_on(reg_on), .bus_good(bg), .main_good(mg), .core_good(cg));
  task automatic wrap_up();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("register", {8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk
  task automatic rails(input logic b, input logic m, input logic c, input int w);
    @(posedge clk);
    bus_on <= b;
    main_on <= m;
    core_ok <= c;
    repeat (w) @(posedge clk);
    #1;
  endtask : rails
  // Waits for the first switch pattern, then times each later one.
  task automatic steps(input logic [15:0] pats, input int n);
    int c;
    logic [3:0] prev;
    c = 0;
    while (fets !== pats[15:12] && c < 40) begin
      @(posedge clk);
      #1;
      c++;
    end
    check("first switch step", 16'(fets), 16'(pats[15:12]));
    for (int k = 1; k < n; k++) begin
      prev = fets;
      c = 0;
      while (fets === prev && c < 6000) begin
        @(posedge clk);
        #1;
        c++;
      end
      check("switch step", 16'(fets), 16'(pats[15-4*k -: 4]));
      check("step delay", 16'(c), 16'h1388);
    end
  endtask : steps
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(16'h1C00, 8'h00);
    rd_chk(16'h1C02, 8'h00);
    check("switches", 16'(fets), 16'h0005);
    check("core reset", 16'(core_rst_n), 16'h0000);
    wr_reg(16'h1C03, 8'h3F);
    rd_chk(16'h1C03, 8'h3F);
    wr_reg(16'h1C05, 8'hFF);
    rd_chk(16'h1C05, 8'h00);
    rails(1'b0, 1'b1, 1'b1, 0);
    steps(16'h4C00, 2);
    rd_chk(16'h1C02, 8'h04);
    check("irq", 16'(irq), 16'h0001);
    check("core reset", 16'(core_rst_n), 16'h0001);
    rd_chk(16'h1C01, 8'h26);
    rd_chk(16'h1C04, 8'h01);
    wr_reg(16'h1C02, 8'h00);
    rd_chk(16'h1C02, 8'h04);
    wr_reg(16'h1C02, 8'h04);
    rd_chk(16'h1C02, 8'h00);
    check("irq", 16'(irq), 16'h0000);
    rails(1'b1, 1'b1, 1'b1, 20);
    rails(1'b0, 1'b1, 1'b1, 20);
    rd_chk(16'h1C02, 8'h03);
    check("switches", 16'(fets), 16'h000C);
    rails(1'b1, 1'b1, 1'b1, 20);
    check("switches", 16'(fets), 16'h000C);
    wr_reg(16'h1C00, 8'h01);
    steps(16'h4513, 4);
    rd_chk(16'h1C02, 8'h23);
    wr_reg(16'h1C02, 8'h3F);
    wr_reg(16'h1C00, 8'h00);
    steps(16'h154C, 4);
    wr_reg(16'h1C02, 8'h3F);
    rails(1'b1, 1'b0, 1'b1, 0);
    steps(16'h4513, 4);
    rd_chk(16'h1C02, 8'h28);
    check("wake", 16'(wake), 16'h0001);
    wr_reg(16'h1C03, 8'h00);
    check("irq", 16'(irq), 16'h0000);
    check("wake", 16'(wake), 16'h0000);
    wr_reg(16'h1C00, 8'h02);
    check("switch enable", 16'(sw_en_n), 16'h0001);
    rails(1'b1, 1'b0, 1'b0, 20);
    check("core reset", 16'(core_rst_n), 16'h0000);
    rails(1'b0, 1'b0, 1'b1, 20);
    check("core reset", 16'(core_rst_n), 16'h0000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rails(1'b1, 1'b0, 1'b1, 0);
    steps(16'h3000, 1);
    rd_chk(16'h1C04, 8'h02);
    check("regulator", 16'(reg_on), 16'h0001);
    wrap_up();
  end
endmodule : dual_supply_switch_sequencer_tb
